// >>> logic/umc_gap_timer.sv
// Stop-bit spacing timer between transmitted characters
`timescale 1ns/1ps
`default_nettype none
module umc_gap_timer
    import umc_pkg::*;
#(
    parameter int unsigned CW = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic char_end,
    input wire logic short_gap,
    input wire logic [1:0] stop_code,
    input wire logic [CW-1:0] half_bit_cycles,
    output logic busy
);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic [2:0] halves;
        logic busy;
    } umc_gap_st_t;

    umc_gap_st_t st_ff;
    umc_gap_st_t nxt_st;

    // A zero divisor still yields one cycle per half bit
    function automatic logic [CW-1:0] reload(input logic [CW-1:0] hbc);
        reload = (hbc == '0) ? '0 : hbc - 1'b1;
    endfunction : reload

    always_comb begin
        nxt_st = st_ff;
        if (char_end) begin
            nxt_st.busy = 1'b1;
            nxt_st.halves = umc_gap_halves(stop_code, short_gap);
            nxt_st.cnt = reload(half_bit_cycles);
        end else if (st_ff.busy) begin
            if (st_ff.cnt != '0) begin
                nxt_st.cnt = st_ff.cnt - 1'b1;
            end else if (st_ff.halves == 3'h1) begin
                nxt_st.busy = 1'b0;
            end else begin
                nxt_st.halves = st_ff.halves - 3'h1;
                nxt_st.cnt = reload(half_bit_cycles);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign busy = st_ff.busy;

    a_half_gap_len: assert property (@(posedge clk) disable iff (!rst_n || !ce)
        (char_end && !st_ff.busy && short_gap && half_bit_cycles == 16'h0002)
        |=> st_ff.busy [*2] ##1 !st_ff.busy)
        else $error("half stop gap length wrong");

endmodule : umc_gap_timer
`default_nettype wire

// >>> logic/umc_modem_ctrl.sv
// Modem line control register with flow control, loopback and gap timing
// Behaviour
// - Bit 0 at 0 drives DTR high, at 1 drives DTR low.
// - Without auto flow, bit 1 at 0 drives RTS high, at 1 low.
// - In loopback, aux output one feeds the internal ring indicator.
// - In loopback, aux output two feeds the internal carrier detect.
// - Bit 4 turns internal loopback on at 1, off at 0.
// - Bit 5 and bit 1 pick auto RTS plus CTS, CTS only, or none.
// - With bit 5 set, bit 1 enables auto RTS instead of driving RTS.
// - Bit 7 shortens the gap between characters to half a stop bit.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module umc_modem_ctrl
    import umc_pkg::*;
#(
    parameter int unsigned CW = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire umc_apb_req_t apb_req,
    output var umc_apb_rsp_t apb_rsp,
    input wire umc_pins_in_t pins_in,
    output var umc_pins_out_t pins_out,
    input wire logic tx_serial,
    input wire logic char_end,
    input wire logic rx_at_trigger,
    input wire logic [1:0] stop_code,
    input wire logic [CW-1:0] half_bit_cycles,
    output var umc_int_out_t int_out
);

    typedef struct packed {
        logic [7:0] mlc;
        umc_apb_rsp_t rsp;
        umc_pins_out_t pins;
        umc_int_out_t io;
    } umc_top_st_t;

    umc_top_st_t st_ff;
    umc_top_st_t nxt_st;
    umc_pins_in_t pin_s;
    logic gap_busy;
    logic hit_mlc;
    logic hit_sts;
    logic access;
    logic commit;
    logic auto_cts;
    logic auto_rts;
    logic loop_on;
    logic diag_on;
    logic [7:0] sts_word;

    umc_sync #(
        .W($bits(umc_pins_in_t))
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .d(pins_in),
        .q(pin_s)
    );

    umc_gap_timer #(
        .CW(CW)
    ) u_gap (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .char_end(char_end),
        .short_gap(st_ff.mlc[UMC_HALF_STOP_BIT]),
        .stop_code(stop_code),
        .half_bit_cycles(half_bit_cycles),
        .busy(gap_busy)
    );

    always_comb begin
        hit_mlc = umc_hit(apb_req.paddr, UMC_MLC_OFS);
        hit_sts = umc_hit(apb_req.paddr, UMC_STS_OFS);
        // One wait state: pready rises in the second access cycle
        access = apb_req.psel && apb_req.penable && !st_ff.rsp.pready;
        commit = apb_req.psel && apb_req.penable && st_ff.rsp.pready;
        loop_on = st_ff.mlc[UMC_LOOP_BIT];
        auto_cts = st_ff.mlc[UMC_AUTO_FLOW_BIT];
        auto_rts = st_ff.mlc[UMC_AUTO_FLOW_BIT] && st_ff.mlc[UMC_RTS_BIT];
        // diagnostic echo when auto flow is off
        diag_on = !st_ff.mlc[UMC_AUTO_FLOW_BIT];
        sts_word = {diag_on, gap_busy, auto_cts, auto_rts,
                    st_ff.io.dcd, st_ff.io.ri, st_ff.io.dsr, st_ff.io.cts};
    end

    always_comb begin
        nxt_st = st_ff;
        if (access) begin
            nxt_st.rsp.pready = 1'b1;
            // Unmapped addresses and writes to status answer with an error
            nxt_st.rsp.pslverr = !(hit_mlc || hit_sts) || (hit_sts && apb_req.pwrite);
            if (apb_req.pwrite) begin
                nxt_st.rsp.prdata = '0;
            end else if (hit_mlc) begin
                nxt_st.rsp.prdata = {24'h00_0000, st_ff.mlc & UMC_MLC_WMASK};
            end else if (hit_sts) begin
                nxt_st.rsp.prdata = {24'h00_0000, sts_word};
            end else begin
                nxt_st.rsp.prdata = '0;
            end
        end else begin
            nxt_st.rsp = '0;
        end
        if (commit && apb_req.pwrite && hit_mlc) begin
            nxt_st.mlc = apb_req.pwdata[7:0] & UMC_MLC_WMASK;
        end
        nxt_st.pins.dtr_n = !st_ff.mlc[UMC_DTR_BIT];
        // bit 1 becomes the auto RTS enable
        // auto RTS drops at the receive trigger
        if (auto_rts) begin
            nxt_st.pins.rts_n = rx_at_trigger;
        end else begin
            nxt_st.pins.rts_n = !st_ff.mlc[UMC_RTS_BIT];
        end
        nxt_st.io.cts = !pin_s.cts_n;
        nxt_st.io.dsr = !pin_s.dsr_n;
        nxt_st.io.ri = loop_on ? st_ff.mlc[UMC_AUX_ONE_BIT] : !pin_s.ri_n;
        nxt_st.io.dcd = loop_on ? st_ff.mlc[UMC_AUX_TWO_BIT] : !pin_s.dcd_n;
        nxt_st.io.rx_serial = diag_on ? tx_serial : pin_s.rx_line;
        // auto CTS gates the next start
        nxt_st.io.tx_start_ok = !gap_busy && !(auto_cts && pin_s.cts_n);
    end

    // reset clears every field except rx_serial, dtr_n and rts_n, which idle high; pins idle deasserted
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.mlc <= UMC_MLC_RST;
            st_ff.pins.dtr_n <= 1'b1;
            st_ff.pins.rts_n <= 1'b1;
            st_ff.io.rx_serial <= 1'b1;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign apb_rsp = st_ff.rsp;
    assign pins_out = st_ff.pins;
    assign int_out = st_ff.io;

    a_dtr_level: assert property (@(posedge clk) disable iff (!rst_n)
        ce |=> pins_out.dtr_n == !$past(st_ff.mlc[UMC_DTR_BIT]))
        else $error("DTR does not follow bit 0");

    a_rts_manual: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !st_ff.mlc[UMC_AUTO_FLOW_BIT]) |=> pins_out.rts_n == !$past(st_ff.mlc[UMC_RTS_BIT]))
        else $error("RTS does not follow bit 1");

    a_ring_loop: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && st_ff.mlc[UMC_LOOP_BIT]) |=> int_out.ri == $past(st_ff.mlc[UMC_AUX_ONE_BIT]))
        else $error("ring indicator not looped");

    a_carrier_loop: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && st_ff.mlc[UMC_LOOP_BIT]) |=> int_out.dcd == $past(st_ff.mlc[UMC_AUX_TWO_BIT]))
        else $error("carrier detect not looped");

    a_loop_off: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !st_ff.mlc[UMC_LOOP_BIT]) |=> int_out.ri == !$past(pin_s.ri_n))
        else $error("ring indicator looped while off");

    a_auto_rts_drop: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && st_ff.mlc[UMC_AUTO_FLOW_BIT] && st_ff.mlc[UMC_RTS_BIT] && rx_at_trigger)
        |=> pins_out.rts_n)
        else $error("auto RTS not dropped at trigger");

    a_auto_rts_ena: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && st_ff.mlc[UMC_AUTO_FLOW_BIT] && st_ff.mlc[UMC_RTS_BIT] && !rx_at_trigger)
        |=> !pins_out.rts_n)
        else $error("auto RTS not asserted below trigger");

    a_cts_only: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && st_ff.mlc[UMC_AUTO_FLOW_BIT] && !st_ff.mlc[UMC_RTS_BIT]) |=> pins_out.rts_n)
        else $error("RTS driven in CTS-only mode");

    a_diag_echo: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !st_ff.mlc[UMC_AUTO_FLOW_BIT]) |=> int_out.rx_serial == $past(tx_serial))
        else $error("transmit data not echoed");

    a_cts_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && st_ff.mlc[UMC_AUTO_FLOW_BIT] && pin_s.cts_n) |=> !int_out.tx_start_ok)
        else $error("start allowed with CTS deasserted");

    a_gap_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && gap_busy) |=> !int_out.tx_start_ok)
        else $error("start allowed during stop gap");

    a_write_store: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && commit && apb_req.pwrite && hit_mlc)
        |=> st_ff.mlc == ($past(apb_req.pwdata[7:0]) & UMC_MLC_WMASK))
        else $error("register write not stored");

    a_rsv_read: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && access && !apb_req.pwrite && hit_mlc) |=> apb_rsp.pready && !apb_rsp.prdata[UMC_RSV_BIT])
        else $error("reserved bit reads nonzero");

    a_apb_wait: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && access) |=> apb_rsp.pready ##1 (!ce || !apb_rsp.pready))
        else $error("pready not a single pulse");

    a_dtr_low: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && st_ff.mlc[UMC_DTR_BIT])
        |=> !pins_out.dtr_n)
        else $error("DTR not driven low");

    a_rts_low: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !st_ff.mlc[UMC_AUTO_FLOW_BIT] && st_ff.mlc[UMC_RTS_BIT])
        |=> !pins_out.rts_n)
        else $error("RTS not driven low");

    a_ring_high: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && st_ff.mlc[UMC_LOOP_BIT] && st_ff.mlc[UMC_AUX_ONE_BIT])
        |=> int_out.ri)
        else $error("ring indicator not set by aux one");

    a_carrier_high: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && st_ff.mlc[UMC_LOOP_BIT] && st_ff.mlc[UMC_AUX_TWO_BIT])
        |=> int_out.dcd)
        else $error("carrier detect not set by aux two");

    a_carrier_pin: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !st_ff.mlc[UMC_LOOP_BIT])
        |=> int_out.dcd == !$past(pin_s.dcd_n))
        else $error("carrier detect looped while off");

    a_rx_from_pin: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && st_ff.mlc[UMC_AUTO_FLOW_BIT])
        |=> int_out.rx_serial == $past(pin_s.rx_line))
        else $error("receive path not from pin");

    a_cts_follow: assert property (@(posedge clk) disable iff (!rst_n)
        ce
        |=> int_out.cts == !$past(pin_s.cts_n))
        else $error("CTS not passed inward");

    a_dsr_follow: assert property (@(posedge clk) disable iff (!rst_n)
        ce
        |=> int_out.dsr == !$past(pin_s.dsr_n))
        else $error("DSR not passed inward");

    a_cts_go: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && st_ff.mlc[UMC_AUTO_FLOW_BIT] && !pin_s.cts_n && !gap_busy)
        |=> int_out.tx_start_ok)
        else $error("start blocked with CTS asserted");

    a_no_flow_go: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !st_ff.mlc[UMC_AUTO_FLOW_BIT] && !gap_busy)
        |=> int_out.tx_start_ok)
        else $error("start blocked without auto CTS");

    a_gap_start: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && char_end)
        |=> gap_busy)
        else $error("stop gap not started");

    a_rsv_write: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && commit && apb_req.pwrite && hit_mlc && apb_req.pwdata[UMC_RSV_BIT])
        |=> !st_ff.mlc[UMC_RSV_BIT])
        else $error("reserved bit stored");

    a_sts_write_drop: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && commit && hit_sts)
        |=> $stable(st_ff.mlc))
        else $error("status write changed register");

    a_mlc_read: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && access && !apb_req.pwrite && hit_mlc)
        |=> apb_rsp.prdata[7:0] == ($past(st_ff.mlc) & UMC_MLC_WMASK))
        else $error("register read data wrong");

    a_flow_flag: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && access && !apb_req.pwrite && hit_sts)
        |=> apb_rsp.prdata[5] == $past(st_ff.mlc[UMC_AUTO_FLOW_BIT]))
        else $error("auto CTS flag wrong");

    a_diag_flag: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && access && !apb_req.pwrite && hit_sts)
        |=> apb_rsp.prdata[7] == !$past(st_ff.mlc[UMC_AUTO_FLOW_BIT]))
        else $error("echo flag wrong");

    a_unmapped_err: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && access && !hit_mlc && !hit_sts)
        |=> apb_rsp.pslverr && apb_rsp.prdata == '0)
        else $error("unmapped access not refused");

    a_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && access)
        |=> apb_rsp.prdata[31:8] == 24'h00_0000)
        else $error("upper read bits nonzero");

    a_ready_idle: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && !apb_req.psel)
        |=> !apb_rsp.pready)
        else $error("pready without select");

    // Reset still acts with the enable low, so only frozen cycles count
    a_freeze_all: assert property (@(posedge clk) disable iff (!rst_n)
        (!ce && rst_n)
        |=> $stable(st_ff))
        else $error("state moved with enable low");

endmodule : umc_modem_ctrl
`default_nettype wire

// >>> logic/umc_pkg.sv
// Shared constants, carriers and helpers of the modem line control block
package umc_pkg;

    localparam int unsigned UMC_AW = 12;
    localparam int unsigned UMC_DW = 32;

    // Register byte offsets
    localparam logic [11:0] UMC_MLC_OFS = 12'h004;
    localparam logic [11:0] UMC_STS_OFS = 12'h008;

    // Field positions of modem_line_ctrl
    localparam int unsigned UMC_DTR_BIT = 0;
    localparam int unsigned UMC_RTS_BIT = 1;
    localparam int unsigned UMC_AUX_ONE_BIT = 2;
    localparam int unsigned UMC_AUX_TWO_BIT = 3;
    localparam int unsigned UMC_LOOP_BIT = 4;
    localparam int unsigned UMC_AUTO_FLOW_BIT = 5;
    localparam int unsigned UMC_RSV_BIT = 6;
    localparam int unsigned UMC_HALF_STOP_BIT = 7;

    // Reset value and writable bits
    localparam logic [7:0] UMC_MLC_RST = 8'h00;
    localparam logic [7:0] UMC_MLC_WMASK = 8'hbf;

    // Gap lengths in half bit times
    localparam logic [2:0] UMC_HALVES_SHORT = 3'h1;
    localparam logic [2:0] UMC_HALVES_ONE = 3'h2;
    localparam logic [2:0] UMC_HALVES_ONE_HALF = 3'h3;
    localparam logic [2:0] UMC_HALVES_TWO = 3'h4;
    localparam logic [1:0] UMC_STOP_CODE_ONE = 2'h0;
    localparam logic [1:0] UMC_STOP_CODE_ONE_HALF = 2'h1;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [UMC_AW-1:0] paddr;
        logic [UMC_DW-1:0] pwdata;
    } umc_apb_req_t;

    typedef struct packed {
        logic [UMC_DW-1:0] prdata;
        logic pready;
        logic pslverr;
    } umc_apb_rsp_t;

    typedef struct packed {
        logic rx_line;
        logic cts_n;
        logic dsr_n;
        logic ri_n;
        logic dcd_n;
    } umc_pins_in_t;

    typedef struct packed {
        logic dtr_n;
        logic rts_n;
    } umc_pins_out_t;

    typedef struct packed {
        logic cts;
        logic dsr;
        logic ri;
        logic dcd;
        logic rx_serial;
        logic tx_start_ok;
    } umc_int_out_t;

    function automatic logic umc_hit(input logic [UMC_AW-1:0] addr, input logic [UMC_AW-1:0] ofs);
        umc_hit = (addr == ofs);
    endfunction : umc_hit

    function automatic logic [2:0] umc_gap_halves(input logic [1:0] code, input logic short_gap);
        if (short_gap) begin
            umc_gap_halves = UMC_HALVES_SHORT;
        end else if (code == UMC_STOP_CODE_ONE) begin
            umc_gap_halves = UMC_HALVES_ONE;
        end else if (code == UMC_STOP_CODE_ONE_HALF) begin
            umc_gap_halves = UMC_HALVES_ONE_HALF;
        end else begin
            umc_gap_halves = UMC_HALVES_TWO;
        end
    endfunction : umc_gap_halves

endpackage : umc_pkg

// >>> logic/umc_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module umc_sync
    import umc_pkg::*;
#(
    parameter int unsigned W = 5
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } umc_sync_st_t;

    umc_sync_st_t st_ff;
    umc_sync_st_t nxt_st;

    // First stage feeds only the second
    always_comb begin
        nxt_st = st_ff;
        nxt_st.meta = d;
        nxt_st.stable = st_ff.meta;
    end

    // Idle pins are high, so reset to all ones
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '1;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.stable;

endmodule : umc_sync
`default_nettype wire

// >>> tb/uart_modem_control_tb.sv
// Self-checking bench of the modem line control block
`timescale 1ns/1ps
`default_nettype none
module uart_modem_control_tb
    import umc_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    umc_apb_req_t req = '0;
    umc_apb_rsp_t rsp;
    umc_pins_in_t pin_i;
    umc_pins_out_t pin_o;
    umc_int_out_t io;
    logic tx_serial = 1'b1;
    logic char_end = 1'b0;
    logic trig = 1'b0;
    logic [1:0] stop_code = 2'h0;
    logic [15:0] hbc = 16'h0001;
    logic [3:0] mood = 4'h0;
    int errors = 0;
    int checks_done = 0;
    int cnt;
    logic [31:0] rd;
    logic err;
    logic [7:0] m;
    logic [7:0] hold;
    logic [7:0] corner [7] = '{8'h00, 8'hff, 8'h22, 8'h20, 8'h02, 8'h1c, 8'h40};

    initial begin
        forever #50 clk = ~clk;
    end

    umc_modem_ctrl #(.CW(16)) dut (.clk(clk), .rst_n(rst_n), .ce(ce), .apb_req(req), .apb_rsp(rsp),
        .pins_in(pin_i), .pins_out(pin_o), .tx_serial(tx_serial), .char_end(char_end),
        .rx_at_trigger(trig), .stop_code(stop_code), .half_bit_cycles(hbc), .int_out(io));
    umc_peer_model peer (.clk(clk), .rst_n(rst_n), .mood(mood), .pins_out(pin_o), .pins_in(pin_i));

    task automatic report_and_stop;
        if (errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Holds the request until pready is seen, no assumed latency
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge clk);
        req.penable <= 1'b1;
        // Pready is taken at the rising edge, with the request still standing
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            report_and_stop();
        end else begin
            rd = rsp.prdata;
            err = rsp.pslverr;
            req.psel <= 1'b0;
            req.penable <= 1'b0;
        end
    endtask : apb

    // Expected {dtr_n, rts_n, cts, dsr, ri, dcd, rx_serial, tx_start_ok}
    function automatic logic [7:0] exp_pins(input logic [7:0] v);
        logic rts;
        rts = (v[5] & v[1]) ? trig : ~v[1];
        exp_pins = {~v[0], rts, ~mood[0], v[0], v[4] ? v[2] : ~mood[1], v[4] ? v[3] : ~mood[2],
            v[5] ? (rts | mood[3]) : tx_serial, ~(v[5] & mood[0])};
    endfunction : exp_pins

    // Expected status {echo, gap, auto CTS, auto RTS, dcd, ri, dsr, cts}
    function automatic logic [7:0] exp_sts(input logic [7:0] v, input logic [7:0] e);
        exp_sts = {~v[5], 1'b0, v[5], v[5] & v[1], e[2], e[3], e[4], e[5]};
    endfunction : exp_sts

    function automatic int gap_len(input logic half, input logic [1:0] sc);
        gap_len = (half ? 1 : (sc == 2'h0) ? 2 : (sc == 2'h1) ? 3 : 4) * int'(hbc);
    endfunction : gap_len

    initial begin
        void'($urandom(98));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, UMC_MLC_OFS, 32'h0000_0000);
        chk("mlc reset", 32'h0000_0000, rd);
        chk("pins reset", 32'h0000_0003, {30'h0, pin_o});
        for (int i = 0; i < 30; i++) begin
            @(posedge clk);
            m = (i < 7) ? corner[i] : 8'($urandom);
            {trig, tx_serial, mood} <= 6'($urandom);
            apb(1'b1, UMC_MLC_OFS, {24'($urandom), m});
            chk("write err", 32'h0000_0000, {31'h0, err});
            apb(1'b0, UMC_MLC_OFS, 32'h0000_0000);
            chk("mlc read", {24'h0, m & 8'hbf}, rd);
            // Sync chain plus peer register needs settling
            repeat (6) @(posedge clk);
            @(negedge clk);
            hold = exp_pins(m & 8'hbf);
            chk("pins", {24'h0, hold}, {24'h0, pin_o, io});
            apb(1'b0, UMC_STS_OFS, 32'h0000_0000);
            chk("status", {24'h0, exp_sts(m, hold)}, rd);
        end
        // Clock enable low freezes all state
        @(posedge clk);
        ce <= 1'b0;
        mood <= ~mood;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("freeze", {24'h0, hold}, {24'h0, pin_o, io});
        @(posedge clk);
        ce <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("resume", {24'h0, exp_pins(m & 8'hbf)}, {24'h0, pin_o, io});
        // Refused accesses leave the register alone
        apb(1'b0, 12'h00c, 32'h0000_0000);
        chk("unmapped err", 32'h0000_0001, {31'h0, err});
        chk("unmapped data", 32'h0000_0000, rd);
        apb(1'b1, 12'h00c, 32'h0000_00ff);
        chk("unmapped write err", 32'h0000_0001, {31'h0, err});
        apb(1'b1, UMC_STS_OFS, 32'h0000_00ff);
        chk("status write err", 32'h0000_0001, {31'h0, err});
        apb(1'b0, UMC_MLC_OFS, 32'h0000_0000);
        chk("mlc kept", {24'h0, m & 8'hbf}, rd);
        for (int g = 0; g < 8; g++) begin
            @(posedge clk);
            stop_code <= g[1:0];
            // Two cycles per half bit once, to reach the timer's own check
            hbc <= (g == 4) ? 16'h0002 : 16'(1 + $urandom % 4);
            mood <= 4'h0;
            // half gap only towards a like peer
            apb(1'b1, UMC_MLC_OFS, {24'h0, g[2], 7'h00});
            @(posedge clk);
            char_end <= 1'b1;
            @(posedge clk);
            char_end <= 1'b0;
            cnt = 0;
            repeat (40) begin
                @(negedge clk);
                if (io.tx_start_ok !== 1'b1) cnt++;
            end
            chk("gap", 32'(gap_len(g[2], g[1:0])), 32'(cnt));
        end
        report_and_stop();
    end
endmodule : uart_modem_control_tb
`default_nettype wire

// >>> tb/umc_peer_model.sv
// Modem peer model driving the handshake pins
`timescale 1ns/1ps
`default_nettype none
module umc_peer_model
    import umc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] mood,
    input wire umc_pins_out_t pins_out,
    output var umc_pins_in_t pins_in
);
    // Pins change only after a clock edge, like a real peer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pins_in <= '1;
        end else begin
            // peer holds CTS off when busy
            pins_in.cts_n <= mood[0];
            pins_in.dsr_n <= pins_out.dtr_n;
            pins_in.ri_n <= mood[1];
            pins_in.dcd_n <= mood[2];
            pins_in.rx_line <= pins_out.rts_n | mood[3];
        end
    end
endmodule : umc_peer_model
`default_nettype wire
